/* File: hw/fgip_top.sv */
// Filtered general input port for two pulse I/O modules
`timescale 1ns/10ps
module fgip_top
    import fgip_pkg::*;
#(
    parameter int unsigned P_FILT_UNIT_CYCLES = fgip_pkg::FILT_UNIT_CYCLES
)
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Input terminals, module 0 in bits 9:0, module 1 in 19:10
    input wire logic [fgip_pkg::N_TERM-1:0] i_terminal,
    // Host scan
    input wire logic i_io_refresh,
    input wire logic i_general_refresh,
    // Register port
    input wire logic [fgip_pkg::ADDR_W-1:0] i_addr,
    input wire logic [fgip_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [fgip_pkg::DATA_W-1:0] o_rdata,
    // Alternate function routing
    output logic [fgip_pkg::N_TERM-1:0] o_alt_quick,
    output logic [fgip_pkg::N_TERM-1:0] o_alt_intr,
    output logic [fgip_pkg::N_TERM-1:0] o_alt_counter,
    output logic [fgip_pkg::N_TERM-1:0] o_alt_origin,
    // Status
    output logic o_general_refresh_ignored
);

    typedef struct packed {
        logic [N_TERM-1:0] sync1;
        logic [N_TERM-1:0] sync2;
        logic [FILT_CODE_W-1:0] code;
        logic [N_TERM-1:0][FSEL_W-1:0] fsel;
        logic [N_PER_MOD-1:0] word0;
        logic [N_PER_MOD-1:0] word1;
        logic [DATA_W-1:0] rdata;
        logic ignored;
        logic [N_TERM-1:0] quick;
        logic [N_TERM-1:0] intr;
        logic [N_TERM-1:0] counter;
        logic [N_TERM-1:0] origin;
    } fgip_state_s;

    fgip_state_s st_r;
    fgip_state_s st_nxt;
    logic [N_TERM-1:0] filt_level;
    logic [N_TERM-1:0] normal_mask;
    logic [N_TERM-1:0] live;
    logic [CNT_W-1:0] threshold;

    // Cycles of stable level for a filter code
    function automatic logic [CNT_W-1:0] thr_of(
        input logic [FILT_CODE_W-1:0] c,
        input int unsigned unit
    );
        logic [31:0] t;
        t = '0;
        if (c != '0)
        begin
            t = 32'(unit) << (c - 3'h1);
        end
        return t[CNT_W-1:0];
    endfunction

    // Address of function select register r
    function automatic logic [ADDR_W-1:0] fsel_addr(input int r);
        logic [ADDR_W-1:0] off;
        off = ADDR_FSEL_STEP * ADDR_W'(r);
        return ADDR_FSEL_BASE + off;
    endfunction

    // Whether terminal t may take function f
    function automatic logic func_ok(input int t, input logic [2:0] f);
        logic ok;
        ok = 1'b0;
        case (f)
            FUNC_NORMAL: ok = 1'b1;
            FUNC_QUICK: ok = CAP_QUICK[t];
            FUNC_INTR: ok = CAP_INTR[t];
            FUNC_COUNTER: ok = CAP_COUNTER[t];
            FUNC_ORIGIN: ok = CAP_ORIGIN[t];
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // One shared setting drives both terminal groups
    assign threshold = thr_of(st_r.code, P_FILT_UNIT_CYCLES);

    genvar g;
    generate
        for (g = 0; g < N_TERM; g++)
        begin : g_flt
            fgip_filter u_flt (
                .i_ref_clk(i_ref_clk),
                .i_reset_n(i_reset_n),
                .i_level(st_r.sync2[g]),
                .i_threshold(threshold),
                .o_level(filt_level[g])
            );
        end
    endgenerate

    always_comb
    begin
        for (int t = 0; t < N_TERM; t++)
        begin
            normal_mask[t] = (st_r.fsel[t] == FUNC_NORMAL);
        end
    end

    assign live = filt_level & normal_mask;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync1 = i_terminal;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.rdata = '0;
        st_nxt.ignored = i_general_refresh;
        // Periodic refresh; the general refresh command is not a trigger
        if (i_io_refresh)
        begin
            st_nxt.word0 = live[N_PER_MOD-1:0];
            st_nxt.word1 = live[N_TERM-1:N_PER_MOD];
        end
        if (i_wr)
        begin
            if (i_addr == ADDR_FILT_CFG)
            begin
                st_nxt.code =
                    i_wdata[FILT_CODE_LSB +: FILT_CODE_W];
            end
            for (int r = 0; r < FSEL_REGS; r++)
            begin
                for (int k = 0; k < FSEL_PER_REG; k++)
                begin
                    // A function the terminal lacks is refused
                    if (i_addr == fsel_addr(r) && func_ok(r * FSEL_PER_REG + k,
                        i_wdata[k*FSEL_W +: FSEL_W]))
                    begin
                        st_nxt.fsel[r*FSEL_PER_REG+k] =
                            i_wdata[k*FSEL_W +: FSEL_W];
                    end
                end
            end
        end
        if (i_rd)
        begin
            case (i_addr)
                ADDR_MOD0_WORD:
                    st_nxt.rdata = DATA_W'(st_r.word0);
                ADDR_MOD1_WORD:
                    st_nxt.rdata = DATA_W'(st_r.word1);
                ADDR_MOD0_LIVE:
                    st_nxt.rdata = DATA_W'(live[N_PER_MOD-1:0]);
                ADDR_MOD1_LIVE:
                    st_nxt.rdata = DATA_W'(live[N_TERM-1:N_PER_MOD]);
                ADDR_FILT_CFG: st_nxt.rdata = DATA_W'(st_r.code);
                default:
                begin
                    for (int r = 0; r < FSEL_REGS; r++)
                    begin
                        if (i_addr == fsel_addr(r))
                        begin
                            for (int k = 0; k < FSEL_PER_REG; k++)
                            begin
                                st_nxt.rdata[k*FSEL_W +: FSEL_W] =
                                    st_r.fsel[r*FSEL_PER_REG+k];
                            end
                        end
                    end
                end
            endcase
        end
        // Alternate functions see the unfiltered synchronised level
        for (int t = 0; t < N_TERM; t++)
        begin
            st_nxt.quick[t] = st_r.sync2[t]
                && st_r.fsel[t] == FUNC_QUICK;
            st_nxt.intr[t] = st_r.sync2[t] && st_r.fsel[t] == FUNC_INTR;
            st_nxt.counter[t] = st_r.sync2[t] && st_r.fsel[t] == FUNC_COUNTER;
            st_nxt.origin[t] = st_r.sync2[t] && st_r.fsel[t] == FUNC_ORIGIN;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            st_r <= '0;
            st_r.code <= FILT_CODE_RESET;
            for (int t = 0; t < N_TERM; t++)
            begin
                st_r.fsel[t] <= FSEL_RESET;
            end
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_alt_quick = st_r.quick;
    assign o_alt_intr = st_r.intr;
    assign o_alt_counter = st_r.counter;
    assign o_alt_origin = st_r.origin;
    assign o_general_refresh_ignored = st_r.ignored;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    refresh_latch_a: assert property (
        i_io_refresh |=> st_r.word0 == $past(live[N_PER_MOD-1:0])
            && st_r.word1 == $past(live[N_TERM-1:N_PER_MOD]))
        else $error("Refresh did not latch terminal levels");

    word_map_a: assert property (
        (i_rd && i_addr == ADDR_MOD1_WORD)
        |=> o_rdata == DATA_W'($past(st_r.word1)) ##1 o_rdata == '0
            || $past(i_rd, 1))
        else $error("Module 1 word read wrong");

    reset_normal_a: assert property (
        $past(!i_reset_n) |-> normal_mask == '1 && o_alt_counter == '0)
        else $error("Terminal not general input after reset");

    filter_default_a: assert property (
        $past(!i_reset_n)
        |-> threshold == CNT_W'(P_FILT_UNIT_CYCLES * 16))
        else $error("Default response time is not 8 ms");

    filter_off_a: assert property (
        (st_r.code == '0) |-> threshold == '0)
        else $error("Zero code left filtering on");

    // Alternate outputs lag the function select by one register stage
    one_function_a: assert property (
        $onehot0({o_alt_quick[2], o_alt_intr[2], o_alt_counter[2],
            o_alt_origin[2], $past(normal_mask[2])}))
        else $error("Terminal serves two functions");

    immediate_read_a: assert property (
        (i_rd && i_addr == ADDR_MOD0_LIVE)
        |=> o_rdata == DATA_W'($past(live[N_PER_MOD-1:0])))
        else $error("Immediate read not current state");

    general_refresh_a: assert property (
        (i_general_refresh && !i_io_refresh)
        |=> $stable(st_r.word0) && $stable(st_r.word1))
        else $error("General refresh updated input words");

    alt_map_a: assert property (
        (o_alt_quick & ~CAP_QUICK) == '0
        && (o_alt_intr & ~CAP_INTR) == '0
        && (o_alt_counter & ~CAP_COUNTER) == '0
        && (o_alt_origin & ~CAP_ORIGIN) == '0)
        else $error("Alternate function on wrong terminal");

    ignored_pulse_a: assert property (
        i_general_refresh |=> o_general_refresh_ignored)
        else $error("General refresh command not flagged");

    read_idle_a: assert property (
        !i_rd |=> o_rdata == '0)
        else $error("Read data present without a read");

    word_upper_a: assert property (
        (i_rd && i_addr == ADDR_MOD0_WORD)
        |=> o_rdata[DATA_W-1:N_PER_MOD] == '0)
        else $error("Unused input word bits not zero");

    alt_route_a: assert property (
        (o_alt_quick | o_alt_intr | o_alt_counter | o_alt_origin)
        == $past(st_r.sync2 & ~normal_mask))
        else $error("Alternate output does not follow its terminal");

    refused_func_a: assert property (
        (i_wr && i_addr == ADDR_FSEL_BASE
            && i_wdata[4*FSEL_W +: FSEL_W] == FUNC_QUICK)
        |=> $stable(st_r.fsel[4]))
        else $error("Quick function taken by a terminal lacking it");

    filter_code_a: assert property (
        (i_wr && i_addr == ADDR_FILT_CFG)
        |=> st_r.code == $past(i_wdata[FILT_CODE_LSB +: FILT_CODE_W]))
        else $error("Filter setting write not taken");

    reset_clear_a: assert property (
        $past(!i_reset_n)
        |-> st_r.word0 == '0 && st_r.word1 == '0 && o_rdata == '0)
        else $error("Input words not cleared by reset");

    cover_ignored_c: cover property (
        i_general_refresh ##1 o_general_refresh_ignored);
    cover_refresh_c: cover property (i_io_refresh ##1 st_r.word0 != '0);
    cover_immediate_c: cover property (i_rd && i_addr == ADDR_MOD1_LIVE);
    cover_counter_c: cover property (o_alt_counter[6]);
    cover_nofilter_c: cover property (st_r.code == '0 ##1 live != '0);

endmodule

/* File: hw/fgip_pkg.sv */
// Constants shared by the filtered general input port
// Summary of operation
// - Periodic refresh latches general inputs into words
// - Module 0 to word 2960, module 1 2962
// - After reset every terminal is general input
// - One filter setting for both modules, default 8ms
// - Seven filter times, codes 1 to 7; zero disables filtering
// - Each terminal serves exactly one function
// - Immediate read returns current terminal state
// - General refresh command does not refresh inputs
// - Bits 00/01: quick, interrupt, origin search
// - Bits 02/03: counter Z, quick, interrupt, origin
// - Bits 04/05: origin search only
package fgip_pkg;

    localparam int N_PER_MOD = 10;
    localparam int N_TERM = 20;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int CNT_W = 20;

    // Word addresses on the register port
    localparam logic [11:0] ADDR_MOD0_WORD = 12'hb90;
    localparam logic [11:0] ADDR_MOD1_WORD = 12'hb92;
    localparam logic [11:0] ADDR_FILT_CFG = 12'hb94;
    localparam logic [11:0] ADDR_FSEL_BASE = 12'hb98;
    localparam logic [11:0] ADDR_FSEL_STEP = 12'h002;
    localparam logic [11:0] ADDR_MOD0_LIVE = 12'hba0;
    localparam logic [11:0] ADDR_MOD1_LIVE = 12'hba2;

    // Filter configuration field
    localparam int FILT_CODE_LSB = 0;
    localparam int FILT_CODE_W = 3;
    localparam logic [2:0] FILT_CODE_RESET = 3'h5;

    // Function select fields: five 3-bit fields per register
    localparam int FSEL_W = 3;
    localparam int FSEL_PER_REG = 5;
    localparam int FSEL_REGS = 4;
    localparam logic [2:0] FUNC_NORMAL = 3'h0;
    localparam logic [2:0] FUNC_QUICK = 3'h1;
    localparam logic [2:0] FUNC_INTR = 3'h2;
    localparam logic [2:0] FUNC_COUNTER = 3'h3;
    localparam logic [2:0] FUNC_ORIGIN = 3'h4;
    localparam logic [2:0] FSEL_RESET = 3'h0;

    // Terminals able to take each alternate function
    localparam logic [19:0] CAP_QUICK = 20'h03c0f;
    localparam logic [19:0] CAP_INTR = 20'h03c0f;
    localparam logic [19:0] CAP_COUNTER = 20'hf33cc;
    localparam logic [19:0] CAP_ORIGIN = 20'h0fc3f;

    // Filter base step of 0.5 ms
    localparam int CLK_PERIOD_NS = 50;
    localparam int FILT_UNIT_NS = 500000;
    localparam int FILT_UNIT_CYCLES = FILT_UNIT_NS / CLK_PERIOD_NS;

endpackage

/* File: hw/fgip_filter.sv */
// Response-time filter for one input terminal
`timescale 1ns/10ps
module fgip_filter
    import fgip_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Synchronised level and selected time in cycles
    input wire logic i_level,
    input wire logic [fgip_pkg::CNT_W-1:0] i_threshold,
    // Accepted level
    output logic o_level
);

    typedef struct packed {
        logic level;
        logic [CNT_W-1:0] cnt;
    } fgip_flt_s;

    fgip_flt_s st_r;
    fgip_flt_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (i_threshold == '0)
        begin
            st_nxt.level = i_level;
            st_nxt.cnt = '0;
        end
        else if (i_level == st_r.level)
        begin
            st_nxt.cnt = '0;
        end
        else if (st_r.cnt >= i_threshold - 1'b1)
        begin
            st_nxt.level = i_level;
            st_nxt.cnt = '0;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_level = st_r.level;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    flt_settle_time_a: assert property (
        (i_threshold != '0 && $past(i_threshold) == i_threshold
            && st_r.level != $past(st_r.level))
        |-> $past(st_r.cnt) >= i_threshold - 1'b1)
        else $error("Level accepted before response time elapsed");

    flt_bypass_a: assert property (
        (i_threshold == '0) |=> (st_r.level == $past(i_level)))
        else $error("Zero setting did not pass level through");

endmodule

/* File: tb/fgip_switches.sv */
// Behavioural bank of switches and sensors on the input terminals
`timescale 1ns/10ps
module fgip_switches
(
    // Clock
    input wire logic i_ref_clk,
    // Commanded levels and contact bounce enables
    input wire logic [19:0] i_level,
    input wire logic [19:0] i_bounce,
    // Terminal levels
    output logic [19:0] o_terminal
);
    logic chatter_r = 1'b0;

    // Bouncing contacts flip every clock around the commanded level
    always_ff @(posedge i_ref_clk)
        chatter_r <= ~chatter_r;

    assign o_terminal = i_level ^ (i_bounce & {20{chatter_r}});
endmodule

/* File: tb/tb_fgip_top.sv */
// Self-checking bench for the filtered general input port
`timescale 1ns/10ps
module tb_fgip_top;
    import fgip_pkg::*;
    localparam int UNIT = 4;
    logic i_ref_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [N_TERM-1:0] lvl = '0;
    logic [N_TERM-1:0] bnc = '0;
    logic [N_TERM-1:0] term;
    logic i_io_refresh = 1'b0;
    logic i_general_refresh = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic [N_TERM-1:0] alt_q, alt_i, alt_c, alt_o;
    logic ign;
    int err_total = 0;
    int n_tests = 0;
    int seed = 32'h7183cb7e;

    fgip_switches u_sw (.i_ref_clk(i_ref_clk), .i_level(lvl),
        .i_bounce(bnc), .o_terminal(term));

    fgip_top #(.P_FILT_UNIT_CYCLES(UNIT)) DUT (.i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n), .i_terminal(term),
        .i_io_refresh(i_io_refresh), .i_general_refresh(i_general_refresh),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_alt_quick(alt_q), .o_alt_intr(alt_i),
        .o_alt_counter(alt_c), .o_alt_origin(alt_o),
        .o_general_refresh_ignored(ign));

    initial
        forever #25 i_ref_clk = ~i_ref_clk;

    task automatic wrap_up;
        $display("Mismatches %0d of %0d comparisons", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rc(input logic [11:0] a, input logic [15:0] exp);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask

    task automatic refresh(input bit gen);
        @(posedge i_ref_clk);
        if (gen)
            i_general_refresh <= 1'b1;
        else
            i_io_refresh <= 1'b1;
        @(posedge i_ref_clk);
        i_general_refresh <= 1'b0;
        i_io_refresh <= 1'b0;
    endtask

    // Which alternate functions a terminal may take
    function automatic bit cap(input int t, input int f);
        int m;
        m = t % 10;
        case (f)
            1, 2: return m < 4;
            3: return m inside {[2:3], [6:9]};
            4: return m < 6;
            default: return 1'b0;
        endcase
    endfunction

    initial
    begin
        #1_000_000;
        err_total++;
        wrap_up();
    end

    initial
    begin
        logic [N_TERM-1:0] r;
        logic [11:0] a;
        logic [15:0] d;
        logic b;
        int n;
        repeat (10) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        rc(ADDR_FILT_CFG, 16'h0005);
        for (int k = 0; k < FSEL_REGS; k++)
            rc(ADDR_FSEL_BASE + 12'(2 * k), 16'h0000);
        rc(ADDR_MOD0_WORD, 16'h0000);
        rc(12'hbfe, 16'h0000);
        wr(ADDR_FILT_CFG, 16'h0000);
        repeat (4)
        begin
            r = 20'($random(seed));
            @(posedge i_ref_clk);
            lvl <= r;
            repeat (5) @(posedge i_ref_clk);
            rc(ADDR_MOD0_LIVE, {6'h0, r[9:0]});
            rc(ADDR_MOD1_LIVE, {6'h0, r[19:10]});
            refresh(1'b0);
            #1;
            chk(16'(ign), 16'h0000);
            rc(ADDR_MOD0_WORD, {6'h0, r[9:0]});
            rc(ADDR_MOD1_WORD, {6'h0, r[19:10]});
            @(posedge i_ref_clk);
            lvl <= ~r;
            repeat (5) @(posedge i_ref_clk);
            refresh(1'b1);
            #1;
            chk(16'(ign), 16'h0001);
            rc(ADDR_MOD0_WORD, {6'h0, r[9:0]});
        end
        wr(ADDR_MOD1_WORD, 16'hffff);
        rc(ADDR_MOD1_WORD, {6'h0, r[19:10]});
        r = '0;
        @(posedge i_ref_clk);
        lvl <= r;
        repeat (5) @(posedge i_ref_clk);
        for (int c = 1; c < 8; c++)
        begin
            n = UNIT << (c - 1);
            wr(ADDR_FILT_CFG, 16'(c));
            @(posedge i_ref_clk);
            bnc <= '1;
            repeat (2 * n) @(posedge i_ref_clk);
            bnc <= '0;
            rc(ADDR_MOD0_LIVE, {6'h0, r[9:0]});
            @(posedge i_ref_clk);
            lvl <= ~r;
            // New level is accepted n + 2 edges after it is driven
            repeat (n) @(posedge i_ref_clk);
            rc(ADDR_MOD1_LIVE, {6'h0, r[19:10]});
            r = ~r;
            rc(ADDR_MOD0_LIVE, {6'h0, r[9:0]});
            rc(ADDR_MOD1_LIVE, {6'h0, r[19:10]});
        end
        wr(ADDR_FILT_CFG, 16'h0000);
        @(posedge i_ref_clk);
        lvl <= '1;
        for (int t = 0; t < N_TERM; t++)
            for (int f = 1; f < 8; f++)
            begin
                a = ADDR_FSEL_BASE + 12'(2 * (t / 5));
                d = 16'(f) << (3 * (t % 5));
                wr(a, 16'h0000);
                wr(a, d);
                rc(a, cap(t, f) ? d : 16'h0000);
                repeat (4) @(posedge i_ref_clk);
                #1;
                case (f)
                    1: b = alt_q[t];
                    2: b = alt_i[t];
                    3: b = alt_c[t];
                    4: b = alt_o[t];
                    default: b = 1'b0;
                endcase
                chk(16'(b), 16'(cap(t, f)));
            end
        wr(ADDR_FSEL_BASE, 16'h0001);
        repeat (5) @(posedge i_ref_clk);
        refresh(1'b0);
        rc(ADDR_MOD0_WORD, 16'h03fe);
        wrap_up();
    end
endmodule
